// ---- verilog/mtr_cfg.svh ----
// constants for the drive monitor counters and meter outputs
`ifndef MTR_CFG_SVH
`define MTR_CFG_SVH
// clock and time figures
`define MTR_CLK_HZ        250000000
`define MTR_CLK_MHZ       250
`define MTR_HOUR_S        3600
`define MTR_AM_RESP0_US   7000
`define MTR_FILT_STEP_US  10000
`define MTR_FILT_SHIFT    3
`define MTR_FRAC_BITS     8
`define MTR_HALF_LSB      19'h00080
// monitor selections
`define MTR_SEL_PWR_HOURS 8'h14
`define MTR_SEL_RUN_HOURS 8'h17
`define MTR_SEL_ENERGY    8'h19
`define MTR_SEL_SAVED     8'h33
// decimal digit selection and clear codes
`define MTR_DIG_NONE      16'h270f
`define MTR_DIG_INT       16'h0000
`define MTR_DIG_TENTH     16'h0001
`define MTR_CLR_DO        32'h00000000
`define MTR_CLR_KEEP      32'h0000270f
`define MTR_EM_TEN        32'h0000000a
`define MTR_TEN           16'h000a
`define MTR_HUNDRED       16'h0064
// full scales, limits, reset values (0.01 Hz, 0.01 A, 0.01 s units)
`define MTR_FREQ_FS_MAX   19'h09c40
`define MTR_FREQ_FS_RST   19'h01770
`define MTR_CUR_MAX_SMALL 19'h0c350
`define MTR_CUR_MAX_LARGE 19'h57e40
`define MTR_FILT_MAX      9'h1f4
`define MTR_FILT_RST      9'h001
`define MTR_PULSE_FULL    31'h000005a0
`define MTR_PULSE_MAX     31'h00000960
`define MTR_AM_FULL       10'h3e8
// register byte offsets
`define MTR_A_MONSEL      8'h00
`define MTR_A_DIGSEL      8'h04
`define MTR_A_FREQ_FS     8'h08
`define MTR_A_CUR_FS      8'h0c
`define MTR_A_FILT        8'h10
`define MTR_A_METER_SRC   8'h14
`define MTR_A_RUN_CLR     8'h18
`define MTR_A_EM_CLR      8'h1c
`define MTR_A_PWR_HRS     8'h20
`define MTR_A_RUN_HRS     8'h24
`define MTR_A_PWR_WRAP    8'h28
`define MTR_A_RUN_WRAP    8'h2c
`define MTR_A_DISP        8'h30
`define MTR_A_AM_CODE     8'h34
`endif

// ---- verilog/mtr_pkg.sv ----
// types shared by the monitor modules
package mtr_pkg;
  typedef logic [15:0] mtr_hours_t;
  typedef logic [18:0] mtr_scale_t;
  typedef enum logic {MTR_DIV_IDLE, MTR_DIV_RUN} mtr_div_state_t;
endpackage

// ---- verilog/mtr_hr_if.sv ----
// link between the monitor top and one hour counter
`timescale 1ns/100ps
`default_nettype none
interface mtr_hr_if;
  logic                count_en;
  logic                clr;
  mtr_pkg::mtr_hours_t hours;
  mtr_pkg::mtr_hours_t wraps;
  modport cnt (input count_en, input clr, output hours, output wraps);
  modport ctl (output count_en, output clr, input hours, input wraps);
endinterface
`default_nettype wire

// ---- verilog/mtr_hour_cnt.sv ----
// hour counter with sub-hour prescaler and wrap count
`timescale 1ns/100ps
`default_nettype none
`include "mtr_cfg.svh"
module mtr_hour_cnt #(
  parameter logic [39:0] HOUR_CYCLES = 40'h0000000001
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic ce,
  mtr_hr_if.cnt     hr
);
  logic [39:0] pre;
  logic        tick;

  // one tick per full prescaler hour; prescaler clears only at a tick, reset or clear,
  // so a partial hour is lost on power-down and kept across stops
  assign tick = hr.count_en && (pre == HOUR_CYCLES - 40'h0000000001);

  // (RL22) prescaled hour count
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pre      <= '0;
      hr.hours <= '0;
      hr.wraps <= '0;
    end else if (ce) begin
      if (hr.clr) begin
        pre      <= '0;
        hr.hours <= '0;
      end else if (tick) begin
        pre      <= '0;
        // (RL3) wrap past maximum
        hr.hours <= hr.hours + 16'h0001;
        // (RL4) count each wrap
        if (hr.hours == 16'hffff) begin
          hr.wraps <= hr.wraps + 16'h0001;
        end
      end else if (hr.count_en) begin
        pre <= pre + 40'h0000000001;
      end
    end
  end

  wrap_to_zero_a: assert property (@(posedge sys_clk) disable iff (rst) // RL3
    ce && !hr.clr && tick && hr.hours == 16'hffff
    |=> hr.hours == 16'h0000 && hr.wraps == 16'($past(hr.wraps) + 16'h0001))
    else $error("hour counter did not wrap to zero");
endmodule
`default_nettype wire

// ---- verilog/mtr_am_filter.sv ----
// analog meter code: ratio to full scale, saturation and smoothing filter
`timescale 1ns/100ps
`default_nettype none
`include "mtr_cfg.svh"
module mtr_am_filter #(
  parameter logic [31:0] FILT_BASE_CYC = 32'h00000001,
  parameter logic [31:0] FILT_STEP_CYC = 32'h00000001
) (
  input  wire logic               sys_clk,
  input  wire logic               rst,
  input  wire logic               ce,
  input  wire mtr_pkg::mtr_scale_t val,
  input  wire mtr_pkg::mtr_scale_t fs,
  input  wire logic [8:0]         filt_set,
  output logic [9:0]              am_code
);
  mtr_pkg::mtr_div_state_t state;
  logic [28:0]             num;
  mtr_pkg::mtr_scale_t     den;
  logic [9:0]              quo;
  logic [3:0]              bitn;
  logic [9:0]              target;
  logic [31:0]             intv_cnt;
  logic [17:0]             y;
  wire  [9:0]              trial;
  wire                     fits;
  wire  [31:0]             intv;
  wire                     upd;
  wire  signed [18:0]      diff;
  wire  [17:0]             next_y;

  // bit-serial divide: slow but tiny, and the filter is far slower anyway
  assign trial  = quo | 10'(10'h001 << bitn);
  assign fits   = (29'(trial) * 29'(den)) <= num;
  // (RL18) update interval grows with the filter setting
  assign intv   = FILT_BASE_CYC + 32'(filt_set) * FILT_STEP_CYC;
  assign upd    = intv_cnt >= intv - 32'h00000001;
  assign diff   = $signed({1'b0, target, 8'h00}) - $signed({1'b0, y});
  assign next_y = 18'($signed({1'b0, y}) + (diff >>> `MTR_FILT_SHIFT));

  // (RL23) linear code, saturated at and above full scale
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state  <= mtr_pkg::MTR_DIV_IDLE;
      num    <= '0;
      den    <= '0;
      quo    <= '0;
      bitn   <= '0;
      target <= '0;
    end else if (ce) begin
      case (state)
        mtr_pkg::MTR_DIV_IDLE: begin
          num <= 29'(val) * 29'(`MTR_AM_FULL);
          den <= fs;
          quo <= '0;
          bitn <= 4'h9;
          // (RL17) never above full scale
          if (fs == '0) begin
            target <= '0;
          end else if (val >= fs) begin
            target <= `MTR_AM_FULL;
          end else begin
            state <= mtr_pkg::MTR_DIV_RUN;
          end
        end
        mtr_pkg::MTR_DIV_RUN: begin
          if (fits) begin
            quo <= trial;
          end
          if (bitn == 4'h0) begin
            target <= fits ? trial : quo;
            state  <= mtr_pkg::MTR_DIV_IDLE;
          end else begin
            bitn <= bitn - 4'h1;
          end
        end
        default: state <= mtr_pkg::MTR_DIV_IDLE;
      endcase
    end
  end

  // (RL19) first-order smoothing, setting zero gives the base response
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      intv_cnt <= '0;
      y        <= '0;
      am_code  <= '0;
    end else if (ce) begin
      if (upd) begin
        intv_cnt <= '0;
        y        <= next_y;
        am_code  <= 10'((19'(next_y) + `MTR_HALF_LSB) >> `MTR_FRAC_BITS);
      end else begin
        intv_cnt <= intv_cnt + 32'h00000001;
      end
    end
  end

  am_only_on_update_a: assert property (@(posedge sys_clk) disable iff (rst) // RL18
    !(ce && upd) |=> $stable(am_code))
    else $error("analog code moved between filter updates");
endmodule
`default_nettype wire

// ---- verilog/mtr_monitor.sv ----
// drive monitor: hour counters, digit truncation, pulse and analog meter outputs
//
// Contract
// (RL1) power-on hours count each full powered hour, shown at selection 20
// (RL2) running hours count each full run hour, hold while stopped, selection 23
// (RL3) either hour counter wraps to zero after 65535 and keeps counting
// (RL4) wraps of each counter are counted in their own wrap counts
// (RL5) writing zero to run-time clear clears running hours only
// (RL6) run-time clear reads back 9999; writing 9999 clears nothing
// (RL7) a powered period shorter than one hour adds nothing
// (RL8) running time below one hour per powered period adds nothing
// (RL9) digit selection 0 drops all fractional digits; 9999 leaves values alone
// (RL10) digit selection 1 drops hundredths, integers pass unchanged
// (RL11) hour and energy monitors keep their format regardless of digit selection
// (RL12) frequency full scale 0 to 400 Hz, initially 60 Hz, for both meters
// (RL13) current full scale up to 500 A or 3600 A, initially rated current
// (RL14) pulse rate proportional to frequency, 1440 per second at full scale
// (RL15) pulse rate proportional to current against current full scale
// (RL16) pulse rate never above 2400 per second
// (RL17) analog output proportional, 10 V at full scale, never above
// (RL18) analog output smoothed by a 0 to 5 s filter, initially 0.01 s
// (RL19) larger filter setting is steadier and slower; zero responds in 7 ms
// (RL20) full scale and filter settings writable at any time
// (RL21) energy meter clear reads back 9999 or 10 after writing zero
// (RL22) hour ticks come from clock prescalers, running one gated by run state
// (RL23) analog code scales linearly to full scale and saturates above it
`timescale 1ns/100ps
`default_nettype none
`include "mtr_cfg.svh"
module mtr_monitor #(
  parameter logic [39:0] HOUR_CYCLES   = 40'(64'(`MTR_HOUR_S) * 64'(`MTR_CLK_HZ)),
  parameter logic [31:0] FILT_BASE_CYC =
    32'((`MTR_AM_RESP0_US * `MTR_CLK_MHZ) >> `MTR_FILT_SHIFT),
  parameter logic [31:0] FILT_STEP_CYC =
    32'((`MTR_FILT_STEP_US * `MTR_CLK_MHZ) >> `MTR_FILT_SHIFT),
  parameter logic        LARGE_CAP     = 1'b0,
  parameter logic [18:0] RATED_CUR     = 19'h01388
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        run_state,
  input  wire logic [15:0] freq_mon,
  input  wire logic [18:0] cur_mon,
  input  wire logic [15:0] mon_value,
  input  wire logic [1:0]  mon_decimals,
  output logic [15:0]      mon_display,
  output logic [1:0]       mon_display_dec,
  output logic             pulse_meter_output,
  output logic [9:0]       analog_meter_output,
  output logic             energy_meter_clr
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  //////////////////////////////////////////////////////////////////////////////
  // settings
  logic [7:0]          monitor_select;
  logic [15:0]         decimal_digit_select;
  mtr_pkg::mtr_scale_t freq_full_scale;
  mtr_pkg::mtr_scale_t current_full_scale;
  logic [8:0]          analog_out_filter_time;
  logic [1:0]          meter_src;
  logic [31:0]         energy_meter_clear;

  // drop digits from a value until keep decimals remain
  function automatic logic [17:0] mtr_trunc(input logic [15:0] v, input logic [1:0] dec,
                                            input logic [1:0] keep);
    if (dec <= keep) begin
      mtr_trunc = {dec, v};
    end else if (dec - keep == 2'h1) begin
      mtr_trunc = {keep, 16'(v / `MTR_TEN)};
    end else begin
      mtr_trunc = {keep, 16'(v / `MTR_HUNDRED)};
    end
  endfunction

  // clamp a written full scale to its limit
  function automatic logic [18:0] mtr_clamp(input logic [31:0] v, input logic [18:0] lim);
    mtr_clamp = (v > 32'(lim)) ? lim : v[18:0];
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // apb decode
  wire        acc_first = psel && penable && !pready;
  wire        wr        = ce && psel && penable && pready && pwrite;
  wire [18:0] cur_max   = LARGE_CAP ? `MTR_CUR_MAX_LARGE : `MTR_CUR_MAX_SMALL;
  wire        hit;
  wire [31:0] rd_data;
  wire        run_clr_hit;

  mtr_hr_if pwr_if ();
  mtr_hr_if run_if ();

  // unmapped or unaligned addresses answer with an error and zero data
  assign hit = (paddr == `MTR_A_MONSEL)  || (paddr == `MTR_A_DIGSEL)   ||
               (paddr == `MTR_A_FREQ_FS) || (paddr == `MTR_A_CUR_FS)   ||
               (paddr == `MTR_A_FILT)    || (paddr == `MTR_A_METER_SRC) ||
               (paddr == `MTR_A_RUN_CLR) || (paddr == `MTR_A_EM_CLR)   ||
               (paddr == `MTR_A_PWR_HRS) || (paddr == `MTR_A_RUN_HRS)  ||
               (paddr == `MTR_A_PWR_WRAP) || (paddr == `MTR_A_RUN_WRAP) ||
               (paddr == `MTR_A_DISP)    || (paddr == `MTR_A_AM_CODE);

  // read mux; (RL6) run-time clear always reads the keep code
  assign rd_data =
    (paddr == `MTR_A_MONSEL)    ? 32'(monitor_select) :
    (paddr == `MTR_A_DIGSEL)    ? 32'(decimal_digit_select) :
    (paddr == `MTR_A_FREQ_FS)   ? 32'(freq_full_scale) :
    (paddr == `MTR_A_CUR_FS)    ? 32'(current_full_scale) :
    (paddr == `MTR_A_FILT)      ? 32'(analog_out_filter_time) :
    (paddr == `MTR_A_METER_SRC) ? 32'(meter_src) :
    (paddr == `MTR_A_RUN_CLR)   ? `MTR_CLR_KEEP :
    (paddr == `MTR_A_EM_CLR)    ? energy_meter_clear :
    (paddr == `MTR_A_PWR_HRS)   ? 32'(pwr_if.hours) :
    (paddr == `MTR_A_RUN_HRS)   ? 32'(run_if.hours) :
    (paddr == `MTR_A_PWR_WRAP)  ? 32'(pwr_if.wraps) :
    (paddr == `MTR_A_RUN_WRAP)  ? 32'(run_if.wraps) :
    (paddr == `MTR_A_DISP)      ? {14'h0000, mon_display_dec, mon_display} :
    (paddr == `MTR_A_AM_CODE)   ? 32'(analog_meter_output) : 32'h00000000;

  // (RL5) only zero clears running hours; power-on hours have no clear
  assign run_clr_hit = wr && (paddr == `MTR_A_RUN_CLR) && (pwdata == `MTR_CLR_DO);

  // one wait state: answer registered in the cycle after the first access cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else if (ce) begin
      pready  <= acc_first;
      pslverr <= acc_first && !hit;
      if (acc_first) begin
        prdata <= hit ? rd_data : 32'h00000000;
      end
    end
  end

  // (RL20) settings take writes in every state, no write lock
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      monitor_select         <= '0;
      decimal_digit_select   <= `MTR_DIG_NONE;
      freq_full_scale        <= `MTR_FREQ_FS_RST;
      current_full_scale     <= RATED_CUR;
      analog_out_filter_time <= `MTR_FILT_RST;
      meter_src              <= '0;
      energy_meter_clear     <= `MTR_CLR_KEEP;
      energy_meter_clr       <= 1'b0;
    end else if (ce) begin
      energy_meter_clr <= wr && (paddr == `MTR_A_EM_CLR) && (pwdata == `MTR_CLR_DO);
      if (wr) begin
        case (paddr)
          `MTR_A_MONSEL:    monitor_select <= pwdata[7:0];
          `MTR_A_DIGSEL:    decimal_digit_select <= pwdata[15:0];
          // (RL12) frequency full scale limited
          `MTR_A_FREQ_FS:   freq_full_scale <= mtr_clamp(pwdata, `MTR_FREQ_FS_MAX);
          // (RL13) current limit by capacity
          `MTR_A_CUR_FS:    current_full_scale <= mtr_clamp(pwdata, cur_max);
          `MTR_A_FILT: begin
            analog_out_filter_time <= 9'(mtr_clamp(pwdata, 19'(`MTR_FILT_MAX)));
          end
          `MTR_A_METER_SRC: meter_src <= pwdata[1:0];
          // (RL21) zero clears energy, the mode code 9999 or 10 stays readable
          `MTR_A_EM_CLR: begin
            if (pwdata == `MTR_EM_TEN || pwdata == `MTR_CLR_KEEP) begin
              energy_meter_clear <= pwdata;
            end
          end
          default: ;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // hour counters
  // (RL1) power-on prescaler runs whenever powered; (RL7) lost at reset
  assign pwr_if.count_en = 1'b1;
  assign pwr_if.clr      = 1'b0;
  // (RL2) (RL8) running prescaler gated by run state, kept across stops
  assign run_if.count_en = run_state;
  assign run_if.clr      = run_clr_hit;

  mtr_hour_cnt #(.HOUR_CYCLES(HOUR_CYCLES)) u_pwr_hours (
    .sys_clk (sys_clk),
    .rst     (rst),
    .ce      (ce),
    .hr      (pwr_if.cnt)
  );

  mtr_hour_cnt #(.HOUR_CYCLES(HOUR_CYCLES)) u_run_hours (
    .sys_clk (sys_clk),
    .rst     (rst),
    .ce      (ce),
    .hr      (run_if.cnt)
  );

  //////////////////////////////////////////////////////////////////////////////
  // monitor display with digit truncation
  wire        fixed_fmt = (monitor_select == `MTR_SEL_PWR_HOURS) ||
                          (monitor_select == `MTR_SEL_RUN_HOURS) ||
                          (monitor_select == `MTR_SEL_ENERGY)    ||
                          (monitor_select == `MTR_SEL_SAVED);
  wire [17:0] src_disp  = (monitor_select == `MTR_SEL_PWR_HOURS) ? {2'h0, pwr_if.hours} :
                          (monitor_select == `MTR_SEL_RUN_HOURS) ? {2'h0, run_if.hours} :
                          {mon_decimals, mon_value};
  wire [17:0] next_disp;

  // (RL9) (RL10) truncation; (RL11) fixed-format monitors bypass it
  assign next_disp = fixed_fmt ? src_disp :
    (decimal_digit_select == `MTR_DIG_INT)   ? mtr_trunc(src_disp[15:0], src_disp[17:16], 2'h0) :
    (decimal_digit_select == `MTR_DIG_TENTH) ? mtr_trunc(src_disp[15:0], src_disp[17:16], 2'h1) :
    src_disp;

  // display registered so the port comes from a flop
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mon_display     <= '0;
      mon_display_dec <= '0;
    end else if (ce) begin
      mon_display     <= next_disp[15:0];
      mon_display_dec <= next_disp[17:16];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pulse meter: phase accumulator toggling at twice the pulse rate
  wire [18:0] pm_val = meter_src[0] ? cur_mon : 19'(freq_mon);
  wire [18:0] pm_fs  = meter_src[0] ? current_full_scale : freq_full_scale;
  wire [30:0] pm_lin = 31'(pm_val) * `MTR_PULSE_FULL;
  wire [30:0] pm_cap = 31'(pm_fs) * `MTR_PULSE_MAX;
  wire [47:0] pm_thr = 48'(pm_fs) * 48'(`MTR_CLK_HZ);
  // (RL16) rate capped at the maximum pulse rate
  wire [47:0] pm_add = {16'h0000, ((pm_lin > pm_cap) ? pm_cap : pm_lin), 1'b0};
  wire [47:0] pm_sum;
  logic [47:0] pm_acc;

  assign pm_sum = pm_acc + pm_add;

  // (RL14) (RL15) rate proportional to value over selected full scale
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pm_acc             <= '0;
      pulse_meter_output <= 1'b0;
    end else if (ce) begin
      if (pm_fs == '0) begin
        pm_acc             <= '0;
        pulse_meter_output <= 1'b0;
      end else if (pm_sum >= pm_thr) begin
        pm_acc             <= pm_sum - pm_thr;
        pulse_meter_output <= !pulse_meter_output;
      end else begin
        pm_acc <= pm_sum;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // analog meter code, 10 mV steps with full scale at 10 V
  wire [18:0] am_val = meter_src[1] ? cur_mon : 19'(freq_mon);
  wire [18:0] am_fs  = meter_src[1] ? current_full_scale : freq_full_scale;

  // (RL17) (RL18) proportional code through the smoothing filter
  mtr_am_filter #(
    .FILT_BASE_CYC (FILT_BASE_CYC),
    .FILT_STEP_CYC (FILT_STEP_CYC)
  ) u_am_filter (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .ce       (ce),
    .val      (am_val),
    .fs       (am_fs),
    .filt_set (analog_out_filter_time),
    .am_code  (analog_meter_output)
  );

  //////////////////////////////////////////////////////////////////////////////
  // checks
  run_clear_a: assert property (run_clr_hit |=> run_if.hours == 16'h0000) // RL5
    else $error("running hours not cleared by zero write");
  clr_readback_a: assert property ( // RL6
    ce && acc_first && !pwrite && paddr == `MTR_A_RUN_CLR |=> prdata == `MTR_CLR_KEEP)
    else $error("run-time clear did not read back 9999");
  keep_on_9999_a: assert property ( // RL6
    wr && paddr == `MTR_A_RUN_CLR && pwdata == `MTR_CLR_KEEP && run_if.hours != 16'h0000 &&
    run_if.hours != 16'hffff
    |=> run_if.hours != 16'h0000)
    else $error("writing 9999 cleared running hours");
  pwr_no_clear_a: assert property ( // RL5
    pwr_if.hours != 16'hffff |=> pwr_if.hours == $past(pwr_if.hours) ||
                                 pwr_if.hours == 16'($past(pwr_if.hours) + 16'h0001))
    else $error("power-on hours moved other than by one");
  stop_hold_a: assert property (!run_state && !run_clr_hit |=> $stable(run_if.hours)) // RL2
    else $error("running hours changed while stopped");
  trunc_int_a: assert property ( // RL9
    ce && !fixed_fmt && decimal_digit_select == `MTR_DIG_INT && src_disp[17:16] == 2'h2
    |=> mon_display == 16'($past(src_disp[15:0]) / `MTR_HUNDRED) && mon_display_dec == 2'h0)
    else $error("integer truncation wrong");
  tenth_keep_a: assert property ( // RL10
    ce && !fixed_fmt && decimal_digit_select == `MTR_DIG_TENTH && src_disp[17:16] == 2'h0
    |=> mon_display == $past(src_disp[15:0]) && mon_display_dec == 2'h0)
    else $error("integer value altered by tenths selection");
  fixed_fmt_a: assert property ( // RL11
    ce && monitor_select == `MTR_SEL_ENERGY
    |=> mon_display == $past(mon_value) && mon_display_dec == $past(mon_decimals))
    else $error("energy monitor format altered");
  am_ceiling_a: assert property (analog_meter_output <= `MTR_AM_FULL) // RL17
    else $error("analog code above full scale");
  fs_limits_a: assert property ( // RL12
    freq_full_scale <= `MTR_FREQ_FS_MAX && current_full_scale <= `MTR_CUR_MAX_LARGE)
    else $error("full scale above limit");
endmodule
`default_nettype wire

// ---- test/mtr_panel_meter.sv ----
// panel meter model: pulse counter and analog reading
`timescale 1ns/100ps
`default_nettype none
module mtr_panel_meter (
  input  wire logic       sys_clk,
  input  wire logic       pulse_in,
  input  wire logic [9:0] level_in,
  output logic [31:0]     pulses,
  output logic [9:0]      reading
);
  logic prev = 1'b0;
  initial pulses = 32'h0;
  always @(posedge sys_clk) begin
    prev <= pulse_in;
    reading <= level_in;
    if (pulse_in && !prev)
      pulses <= pulses + 32'h1;
  end
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
// self-checking bench for the drive monitor
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        sys_clk, rst, ce, psel, penable, pwrite, run_state, pready, pslverr, pmo, emc;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, lfsr, pulses;
  logic [15:0] freq_mon, mon_value, mon_display, v;
  logic [18:0] cur_mon;
  logic [1:0]  mon_decimals, mon_display_dec, d;
  logic [9:0]  amo, reading;
  logic [32:0] exp_q[$];
  logic [15:0] dsel[3] = '{16'h0000, 16'h0001, 16'h270f};
  int          miscompares, tests_run, cyc, t0, clr_seen, hp;
  mtr_monitor #(.HOUR_CYCLES(40'h64), .FILT_BASE_CYC(32'h4), .FILT_STEP_CYC(32'h2)) dut (
    .sys_clk(sys_clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .run_state(run_state), .freq_mon(freq_mon), .cur_mon(cur_mon), .mon_value(mon_value),
    .mon_decimals(mon_decimals), .mon_display(mon_display), .mon_display_dec(mon_display_dec),
    .pulse_meter_output(pmo), .analog_meter_output(amo), .energy_meter_clr(emc));
  mtr_panel_meter meter (.sys_clk(sys_clk), .pulse_in(pmo), .level_in(amo), .pulses(pulses),
    .reading(reading));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // read results are judged as they appear; clear pulses are counted here and judged after the clear write
  always @(posedge sys_clk) begin
    cyc <= rst ? 0 : cyc + 1;
    if (emc === 1'b1)
      clr_seen++;
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
      tests_run++;
      if ({pslverr, prdata} !== exp_q[0]) begin
        miscompares++;
        $display("wrong value at %0t exp %h got %h", $time, exp_q[0], {pslverr, prdata});
      end
      void'(exp_q.pop_front());
    end
  end
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dt);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dt;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic near(input logic [9:0] e);
    repeat (1500) @(posedge sys_clk);
    tests_run++;
    if ((reading + 10'h1 >= e && reading <= e + 10'h1) !== 1'b1) begin
      miscompares++;
      $display("wrong value at %0t exp %h got %h", $time, e, reading);
    end
  endtask
  task automatic print_verdict;
    $display("tests_run %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    // tests take about 58k cycles, most of it the pulse wait
    #320000;
    miscompares++;
    print_verdict();
  end
  initial begin
    {rst, ce, psel, penable, pwrite, run_state} = 6'b110000;
    {paddr, pwdata, freq_mon, cur_mon, mon_value, mon_decimals} = '0;
    {miscompares, tests_run, clr_seen, cyc} = '0;
    lfsr = 32'h0895;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rd(8'h08, 33'h1770);
    rd(8'h0c, 33'h1388);
    rd(8'h10, 33'h1);
    rd(8'h04, 33'h270f);
    rd(8'h38, 33'h100000000);
    apb(1'b1, 8'h08, 32'hc350);
    rd(8'h08, 33'h9c40);
    apb(1'b1, 8'h0c, 32'hea60);
    rd(8'h0c, 33'hc350);
    apb(1'b1, 8'h08, 32'h1770);
    apb(1'b1, 8'h0c, 32'h1388);
    apb(1'b1, 8'h10, 32'h0);
    run_state <= 1'b1;
    apb(1'b1, 8'h18, 32'h0);
    t0 = cyc;
    wait (cyc == t0 + 50);
    rd(8'h24, 33'h0);
    rd(8'h18, 33'h270f);
    wait (cyc == t0 + 250);
    rd(8'h24, 33'h2);
    run_state <= 1'b0;
    apb(1'b1, 8'h18, 32'h270f);
    repeat (300) @(posedge sys_clk);
    rd(8'h24, 33'h2);
    wait (cyc % 100 == 50);
    rd(8'h20, 33'(cyc / 100));
    rd(8'h28, 33'h0);
    apb(1'b1, 8'h00, 32'h1);
    for (int i = 0; i < 9; i++) begin
      apb(1'b1, 8'h04, {16'h0, dsel[i / 3]});
      lfsr = nxt(lfsr);
      mon_value <= lfsr[15:0];
      mon_decimals <= 2'(i % 3);
      repeat (3) @(posedge sys_clk);
      v = lfsr[15:0];
      d = 2'(i % 3);
      if (i / 3 == 0 && d != 2'h0) begin
        v = (d == 2'h1) ? v / 16'ha : v / 16'h64;
        d = 2'h0;
      end else if (i / 3 == 1 && d == 2'h2) begin
        v = v / 16'ha;
        d = 2'h1;
      end
      rd(8'h30, {15'h0, d, v});
    end
    apb(1'b1, 8'h00, 32'h19);
    apb(1'b1, 8'h04, 32'h0);
    repeat (3) @(posedge sys_clk);
    rd(8'h30, {15'h0, mon_decimals, mon_value});
    apb(1'b1, 8'h00, 32'h17);
    rd(8'h30, 33'h2);
    freq_mon <= 16'h2ee0;
    near(10'h3e8);
    freq_mon <= 16'h0bb8;
    near(10'h1f4);
    apb(1'b1, 8'h14, 32'h2);
    cur_mon <= 19'h009c4;
    near(10'h1f4);
    apb(1'b1, 8'h1c, 32'h0);
    @(posedge sys_clk);
    tests_run++;
    if (clr_seen !== 1) begin
      miscompares++;
      $display("wrong value at %0t exp %h got %h", $time, 1, clr_seen);
    end
    rd(8'h1c, 33'h270f);
    // zero scale empties the accumulator, so the first toggle is timed from zero
    apb(1'b1, 8'h08, 32'h0);
    apb(1'b1, 8'h08, 32'h1770);
    // far above full scale: capped at 2400/s, a toggle every 250e6/4800 cycles
    freq_mon <= 16'hffff;
    t0 = cyc;
    wait (pulses == 32'h1);
    hp = cyc - t0 - 250000000 / 4800;
    tests_run++;
    if (hp < -4 || hp > 4) begin
      miscompares++;
      $display("wrong value at %0t exp %h got %h", $time, 250000000 / 4800, cyc - t0);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
